// ### rtl/gcr_global_control.sv
`timescale 1ns/10ps
module gcr_global_control
  import gcr_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int PAIRS = 7,
  parameter int REF_INPUTS = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // device events in
  input wire logic sync_pin,
  input wire logic alarm_present,
  input wire logic gpi_pulse_req,
  input wire logic synth_loop_locked,
  // loop and core controls
  output logic ref_cleanup_loop_en,
  output logic synth_loop_en,
  output logic sysref_timer_en,
  output logic ext_osc_sel,
  output logic core_high_en,
  output logic core_low_en,
  // channel and reference controls
  output logic [2*PAIRS-1:0] chan_en,
  output logic [REF_INPUTS-1:0] ref_path_en,
  output logic ref_one_ext_osc,
  output logic ref_zero_rf_sync,
  // event pulses out
  output logic synth_sync_pulse,
  output logic pulse_gen_req,
  output logic alarm_clear,
  output logic lock_sync_event
);

  // address match, used by write and read decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
    hit = (a == off[ADDR_W-1:0]);
  endfunction

  // stored registers
  logic [7:0] loop_core_q; // loop, timer and core enables
  logic [7:0] chan_pair_q; // channel pair enables
  logic [7:0] mode_ref_q; // sync mode and reference paths
  logic [7:0] alarm_clr_q; // upper bits kept, bit 0 is a trigger
  logic [7:0] rsvd_misc_q; // reserved, read/write only
  logic [7:0] scratch_q; // scratchpad, drives nothing
  logic [7:0] lock_sync_q; // sync at lock control
  logic [7:0] rd_data_d; // read mux
  logic [7:0] rd_data_q; // read data flop
  // event state
  logic sync_pin_q; // previous sync pin level
  logic locked_q; // previous lock level
  logic sync_rise; // sync pin rising edge
  logic synth_sync_q; // sync through loop pulse
  logic pulse_gen_q; // burst request pulse
  logic alarm_clear_q; // clear-alarms pulse
  logic lock_evt_q; // sync at lock pulse
  gcr_sync_mode_t sync_mode; // current sync pin mode
  gcr_core_sel_t core_sel; // current core select

  // register writes; reserved bits kept as written
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loop_core_q <= GCR_RESET_VAL;
      chan_pair_q <= GCR_RESET_VAL;
      mode_ref_q <= GCR_RESET_VAL;
      alarm_clr_q <= GCR_RESET_VAL;
      rsvd_misc_q <= GCR_RESET_VAL;
      scratch_q <= GCR_RESET_VAL;
      lock_sync_q <= GCR_RESET_VAL;
    end else if (wr_en) begin
      if (hit(reg_addr, GCR_ADDR_LOOP_CORE)) begin
        loop_core_q <= wr_data;
      end
      if (hit(reg_addr, GCR_ADDR_CHAN_PAIR)) begin
        chan_pair_q <= wr_data;
      end
      if (hit(reg_addr, GCR_ADDR_MODE_REF)) begin
        mode_ref_q <= wr_data;
      end
      if (hit(reg_addr, GCR_ADDR_ALARM_CLR)) begin
        alarm_clr_q <= {wr_data[7:1], 1'b0};
      end
      if (hit(reg_addr, GCR_ADDR_RSVD_MISC)) begin
        rsvd_misc_q <= wr_data;
      end
      if (hit(reg_addr, GCR_ADDR_SCRATCH)) begin
        scratch_q <= wr_data;
      end
      if (hit(reg_addr, GCR_ADDR_LOCK_SYNC)) begin
        lock_sync_q <= wr_data;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_data_d = 8'h00;
    if (hit(reg_addr, GCR_ADDR_LOOP_CORE)) begin
      rd_data_d = loop_core_q;
    end else if (hit(reg_addr, GCR_ADDR_CHAN_PAIR)) begin
      rd_data_d = chan_pair_q;
    end else if (hit(reg_addr, GCR_ADDR_MODE_REF)) begin
      rd_data_d = mode_ref_q;
    end else if (hit(reg_addr, GCR_ADDR_ALARM_CLR)) begin
      rd_data_d = alarm_clr_q;
    end else if (hit(reg_addr, GCR_ADDR_RSVD_MISC)) begin
      rd_data_d = rsvd_misc_q;
    end else if (hit(reg_addr, GCR_ADDR_SCRATCH)) begin
      rd_data_d = scratch_q;
    end else if (hit(reg_addr, GCR_ADDR_LOCK_SYNC)) begin
      rd_data_d = lock_sync_q;
    end
  end

  // read data captured on rd_en, held otherwise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= GCR_RESET_VAL;
    end else if (rd_en) begin
      rd_data_q <= rd_data_d;
    end
  end
  assign rd_data = rd_data_q;

  assign ref_cleanup_loop_en = loop_core_q[GCR_BIT_REF_LOOP_EN];
  assign synth_loop_en = loop_core_q[GCR_BIT_SYN_LOOP_EN];
  assign sysref_timer_en = loop_core_q[GCR_BIT_SYSREF_EN];

  assign core_sel = gcr_core_sel_t'(loop_core_q[GCR_POS_CORE_SEL +: 2]);
  // code 11 is undefined; treated as both cores off, internal path idle
  assign ext_osc_sel = (core_sel == GCR_CORE_EXTERNAL);
  assign core_high_en = (core_sel == GCR_CORE_HIGH);
  assign core_low_en = (core_sel == GCR_CORE_LOW);

  // one pair bit fans out to two channels
  for (genvar k = 0; k < PAIRS; k++) begin : g_pair
    assign chan_en[2*k] = chan_pair_q[k];
    assign chan_en[2*k+1] = chan_pair_q[k];
  end

  assign ref_path_en = mode_ref_q[GCR_POS_REF_PATH +: REF_INPUTS];
  assign ref_one_ext_osc = mode_ref_q[GCR_BIT_REF1_EXTOSC];
  assign ref_zero_rf_sync = mode_ref_q[GCR_BIT_REF0_RFSYNC];

  assign sync_mode = gcr_sync_mode_t'(mode_ref_q[GCR_POS_SYNC_MODE +: 2]);

  // previous levels for edge detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_pin_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      sync_pin_q <= sync_pin;
      locked_q <= synth_loop_locked;
    end
  end
  // only the rising edge counts; a held-high pin fires once
  assign sync_rise = sync_pin & ~sync_pin_q;

  // sync pin dispatch by mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      synth_sync_q <= 1'b0;
      pulse_gen_q <= 1'b0;
    end else begin
      synth_sync_q <= 1'b0;
      // gpi request always starts a burst
      pulse_gen_q <= gpi_pulse_req;
      case (sync_mode)
        GCR_SYNC_OFF: begin
        end
        GCR_SYNC_THROUGH: begin
          synth_sync_q <= sync_rise;
        end
        GCR_SYNC_PULSEGEN: begin
          pulse_gen_q <= gpi_pulse_req | sync_rise;
        end
        GCR_SYNC_ALARM_SEL: begin
          synth_sync_q <= sync_rise & alarm_present;
          pulse_gen_q <= gpi_pulse_req | (sync_rise & ~alarm_present);
        end
        default: begin
        end
      endcase
    end
  end
  assign synth_sync_pulse = synth_sync_q;
  assign pulse_gen_req = pulse_gen_q;

  // clear pulse on write of one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_clear_q <= 1'b0;
    end else begin
      alarm_clear_q <= wr_en & hit(reg_addr, GCR_ADDR_ALARM_CLR)
                       & wr_data[GCR_BIT_CLR_ALARMS];
    end
  end
  assign alarm_clear = alarm_clear_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_evt_q <= 1'b0;
    end else begin
      lock_evt_q <= synth_loop_locked & ~locked_q
                    & ~lock_sync_q[GCR_BIT_LOCK_SYNC_DIS];
    end
  end
  assign lock_sync_event = lock_evt_q;

  // checks beside the logic
  a_core_high_sel: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && hit(reg_addr, GCR_ADDR_LOOP_CORE) && wr_data[4:3] == 2'h1)
    |=> (core_high_en && !core_low_en && !ext_osc_sel))
    else $error("core select 01 did not pick high core");
  a_sysref_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && hit(reg_addr, GCR_ADDR_LOOP_CORE)) |=> (sysref_timer_en == $past(wr_data[2])))
    else $error("sysref timer enable not from bit 2");
  a_synth_loop_en: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && hit(reg_addr, GCR_ADDR_LOOP_CORE)) |=> (synth_loop_en == $past(wr_data[1])))
    else $error("synthesis loop enable not from bit 1");
  a_ref_loop_en: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && hit(reg_addr, GCR_ADDR_LOOP_CORE)) |=> (ref_cleanup_loop_en == $past(wr_data[0])))
    else $error("cleanup loop enable not from bit 0");
  a_pair_top: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && hit(reg_addr, GCR_ADDR_CHAN_PAIR)) |=> (chan_en[13:12] == {2{$past(wr_data[6])}}))
    else $error("pair bit 6 does not drive channels 12 and 13");
  a_sync_off: assert property (@(posedge core_clk) disable iff (rst)
    (sync_mode == GCR_SYNC_OFF && !gpi_pulse_req) |=> (!synth_sync_pulse && !pulse_gen_req))
    else $error("disabled sync pin produced an event");
  a_sync_through: assert property (@(posedge core_clk) disable iff (rst)
    (sync_mode == GCR_SYNC_THROUGH && sync_pin && !$past(sync_pin)) |=> synth_sync_pulse)
    else $error("sync edge not passed through loop");
  a_sync_burst: assert property (@(posedge core_clk) disable iff (rst)
    (sync_mode == GCR_SYNC_PULSEGEN && sync_pin && !$past(sync_pin))
    |=> (pulse_gen_req && !synth_sync_pulse))
    else $error("mode 10 edge did not start burst");
  a_sync_alarm: assert property (@(posedge core_clk) disable iff (rst)
    (sync_mode == GCR_SYNC_ALARM_SEL && sync_pin && !$past(sync_pin) && alarm_present)
    |=> (synth_sync_pulse && (pulse_gen_req == $past(gpi_pulse_req))))
    else $error("mode 11 with alarm did not sync");
  a_ref_modes: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && hit(reg_addr, GCR_ADDR_MODE_REF))
    |=> (ref_one_ext_osc == $past(wr_data[5]) && ref_zero_rf_sync == $past(wr_data[4])
         && ref_path_en == $past(wr_data[3:0])))
    else $error("reference mode bits misplaced");
  a_clear_pulse: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && hit(reg_addr, GCR_ADDR_ALARM_CLR) && wr_data[0])
    |=> (alarm_clear && alarm_clr_q[GCR_BIT_CLR_ALARMS] == 1'b0))
    else $error("alarm clear not pulsed");
  a_scratch_back: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && hit(reg_addr, GCR_ADDR_SCRATCH))
    ##1 !wr_en
    ##1 (rd_en && !wr_en && hit(reg_addr, GCR_ADDR_SCRATCH))
    |=> (rd_data == $past(wr_data, 3)))
    else $error("scratchpad readback mismatch");
  a_lock_sync: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(synth_loop_locked) && !lock_sync_q[0]) |=> lock_sync_event)
    else $error("no sync event at lock");
  a_lock_nosync: assert property (@(posedge core_clk) disable iff (rst)
    ($past(lock_sync_q[0]) && lock_sync_q[0]) |-> !lock_sync_event)
    else $error("sync at lock while disabled");

endmodule // gcr_global_control

// ### rtl/gcr_pkg.sv
package gcr_pkg;
  // register offsets on the device register port
  localparam logic [15:0] GCR_ADDR_LOOP_CORE = 16'h0003;
  localparam logic [15:0] GCR_ADDR_CHAN_PAIR = 16'h0004;
  localparam logic [15:0] GCR_ADDR_MODE_REF = 16'h0005;
  localparam logic [15:0] GCR_ADDR_ALARM_CLR = 16'h0006;
  localparam logic [15:0] GCR_ADDR_RSVD_MISC = 16'h0007;
  localparam logic [15:0] GCR_ADDR_SCRATCH = 16'h0008;
  localparam logic [15:0] GCR_ADDR_LOCK_SYNC = 16'h0009;

  // loop and core enable register fields
  localparam int GCR_BIT_REF_LOOP_EN = 0;
  localparam int GCR_BIT_SYN_LOOP_EN = 1;
  localparam int GCR_BIT_SYSREF_EN = 2;
  localparam int GCR_POS_CORE_SEL = 3;

  // mode and reference register fields
  localparam int GCR_POS_REF_PATH = 0;
  localparam int GCR_BIT_REF0_RFSYNC = 4;
  localparam int GCR_BIT_REF1_EXTOSC = 5;
  localparam int GCR_POS_SYNC_MODE = 6;

  // single-bit fields of the trigger and lock registers
  localparam int GCR_BIT_CLR_ALARMS = 0;
  localparam int GCR_BIT_LOCK_SYNC_DIS = 0;

  // value of every register after reset
  localparam logic [7:0] GCR_RESET_VAL = 8'h00;

  // oscillator core select codes
  typedef enum logic [1:0] {
    GCR_CORE_EXTERNAL = 2'h0,
    GCR_CORE_HIGH = 2'h1,
    GCR_CORE_LOW = 2'h2,
    GCR_CORE_UNUSED = 2'h3
  } gcr_core_sel_t;

  // sync pin mode codes
  typedef enum logic [1:0] {
    GCR_SYNC_OFF = 2'h0,
    GCR_SYNC_THROUGH = 2'h1,
    GCR_SYNC_PULSEGEN = 2'h2,
    GCR_SYNC_ALARM_SEL = 2'h3
  } gcr_sync_mode_t;
endpackage

// ### tb/gcr_host_model.sv
`timescale 1ns/10ps
// host side of the register port: one strobe per access, driven on the falling edge
module gcr_host_model
  import gcr_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register port
  output logic wr_en,
  output logic rd_en,
  output logic [15:0] reg_addr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  // bus quiet at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    reg_addr = 16'hFFFF;
    wr_data = 8'hFF;
  end

  // released bus shows inverted values, so a stale copy cannot pass
  task automatic idle();
    wr_en = 1'b0;
    rd_en = 1'b0;
    reg_addr = ~reg_addr;
    wr_data = ~wr_data;
  endtask

  // one write, taken at the next rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge core_clk);
    idle();
  endtask

  // one read; data is sampled a full cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    rd_en = 1'b1;
    @(negedge core_clk);
    idle();
    @(negedge core_clk);
    d = rd_data;
  endtask
endmodule // gcr_host_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
// self-checking bench for the global control register bank
module tb_top
  import gcr_pkg::*;
;
  // clock, reset and device events
  logic core_clk, rst, sync_pin, alarm_present, gpi_pulse_req, synth_loop_locked;
  // register port
  logic wr_en, rd_en;
  logic [15:0] reg_addr;
  logic [7:0] wr_data, rd_data, rv;
  // controls and event pulses
  logic ref_cleanup_loop_en, synth_loop_en, sysref_timer_en, ext_osc_sel, core_high_en;
  logic core_low_en, ref_one_ext_osc, ref_zero_rf_sync;
  logic synth_sync_pulse, pulse_gen_req, alarm_clear, lock_sync_event;
  logic [13:0] chan_en;
  logic [3:0] ref_path_en;
  logic [5:0] ctl;
  // bookkeeping
  int miscompares, cmp_count;
  int n_sync = 0, n_pg = 0, n_clr = 0, n_lock = 0, s0, p0, c0, l0;

  assign ctl = {ext_osc_sel, core_high_en, core_low_en, sysref_timer_en, synth_loop_en,
    ref_cleanup_loop_en};

  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  gcr_global_control dut (.core_clk(core_clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
    .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data), .sync_pin(sync_pin),
    .alarm_present(alarm_present), .gpi_pulse_req(gpi_pulse_req),
    .synth_loop_locked(synth_loop_locked), .ref_cleanup_loop_en(ref_cleanup_loop_en),
    .synth_loop_en(synth_loop_en), .sysref_timer_en(sysref_timer_en),
    .ext_osc_sel(ext_osc_sel), .core_high_en(core_high_en), .core_low_en(core_low_en),
    .chan_en(chan_en), .ref_path_en(ref_path_en), .ref_one_ext_osc(ref_one_ext_osc),
    .ref_zero_rf_sync(ref_zero_rf_sync), .synth_sync_pulse(synth_sync_pulse),
    .pulse_gen_req(pulse_gen_req), .alarm_clear(alarm_clear),
    .lock_sync_event(lock_sync_event));

  gcr_host_model host (.core_clk(core_clk), .wr_en(wr_en), .rd_en(rd_en),
    .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data));

  // pulse counters; window counts tolerate either output latency
  always @(negedge core_clk) begin
    n_sync <= n_sync + int'(synth_sync_pulse === 1'b1);
    n_pg <= n_pg + int'(pulse_gen_req === 1'b1);
    n_clr <= n_clr + int'(alarm_clear === 1'b1);
    n_lock <= n_lock + int'(lock_sync_event === 1'b1);
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic snap();
    {s0, p0, c0, l0} = {n_sync, n_pg, n_clr, n_lock};
  endtask

  // settle, then compare pulses seen since the snapshot
  task automatic chk_pulses(input int es, input int ep, input int ec, input int el);
    repeat (3) @(negedge core_clk);
    chk_cnt(n_sync - s0, es);
    chk_cnt(n_pg - p0, ep);
    chk_cnt(n_clr - c0, ec);
    chk_cnt(n_lock - l0, el);
  endtask

  task automatic t_reset();
    for (int a = 3; a <= 10; a++) begin
      host.rd(16'(a), rv);
      chk_val(16'(rv), 16'h0000);
    end
    chk_val(16'(ctl), 16'h0020);
    $display("t_reset done");
  endtask

  task automatic t_core();
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = 8'((c << 3) | (7 - c));
      host.wr(GCR_ADDR_LOOP_CORE, v);
      chk_val(16'(ctl[2:0]), 16'(v[2:0]));
      chk_val(16'(ctl[5:3]), 16'({c == 0, c == 1, c == 2}));
      host.rd(GCR_ADDR_LOOP_CORE, rv);
      chk_val(16'(rv), 16'(v));
    end
    $display("t_core done");
  endtask

  task automatic t_chan();
    for (int k = 0; k < 8; k++) begin
      host.wr(GCR_ADDR_CHAN_PAIR, 8'(1 << k));
      chk_val(16'(chan_en), 16'((32'h3 << (2 * k)) & 32'h3FFF));
    end
    $display("t_chan done");
  endtask

  task automatic t_ref();
    logic [7:0] v;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'h1A : 8'h25;
      host.wr(GCR_ADDR_MODE_REF, v);
      chk_val(16'({ref_one_ext_osc, ref_zero_rf_sync, ref_path_en}), 16'(v[5:0]));
    end
    $display("t_ref done");
  endtask

  // pin held high for several cycles must still give one event in modes 01 to 11
  task automatic t_sync();
    for (int m = 0; m < 4; m++) begin
      for (int al = 0; al < 2; al++) begin
        host.wr(GCR_ADDR_MODE_REF, 8'(m << 6));
        alarm_present = al[0];
        snap();
        sync_pin = 1'b1;
        repeat (5) @(negedge core_clk);
        sync_pin = 1'b0;
        chk_pulses(int'(m == 1 || (m == 3 && al == 1)), int'(m == 2 || (m == 3 && al == 0)),
          0, 0);
      end
    end
    snap();
    gpi_pulse_req = 1'b1;
    @(negedge core_clk);
    gpi_pulse_req = 1'b0;
    chk_pulses(0, 1, 0, 0);
    $display("t_sync done");
  endtask

  task automatic t_clear();
    snap();
    host.wr(GCR_ADDR_ALARM_CLR, 8'hFF);
    chk_pulses(0, 0, 1, 0);
    host.rd(GCR_ADDR_ALARM_CLR, rv);
    chk_val(16'(rv), 16'h00FE);
    snap();
    host.wr(GCR_ADDR_ALARM_CLR, 8'hFE);
    chk_pulses(0, 0, 0, 0);
    $display("t_clear done");
  endtask

  // back-to-back write and read; controls keep the core test's last setting
  task automatic t_scratch();
    host.wr(GCR_ADDR_SCRATCH, 8'hA5);
    host.rd(GCR_ADDR_SCRATCH, rv);
    chk_val(16'(rv), 16'h00A5);
    host.wr(GCR_ADDR_SCRATCH, 8'h5A);
    host.rd(GCR_ADDR_SCRATCH, rv);
    chk_val(16'(rv), 16'h005A);
    chk_val(16'(ctl), 16'h0004);
    $display("t_scratch done");
  endtask

  task automatic t_lock();
    for (int d = 0; d < 2; d++) begin
      host.wr(GCR_ADDR_LOCK_SYNC, 8'(d));
      snap();
      synth_loop_locked = 1'b1;
      repeat (4) @(negedge core_clk);
      synth_loop_locked = 1'b0;
      chk_pulses(0, 0, 0, 1 - d);
    end
    $display("t_lock done");
  endtask

  task automatic close_out();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // main sequence, inputs change on the falling edge
  initial begin
    {rst, sync_pin, alarm_present, gpi_pulse_req, synth_loop_locked} = 5'h10;
    miscompares = 0;
    cmp_count = 0;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_core();
    t_chan();
    t_ref();
    t_sync();
    t_clear();
    t_scratch();
    t_lock();
    close_out();
  end

  // watchdog, about 25 times the expected run length
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
endmodule // tb_top
